// [verilog/dabc_top.sv]
// Purpose: gate debug, scan and trace ports; sequence the boot loader
// Assumes: pins arrive asynchronous; host keeps scan clock limits
// Notes:   the scan/debug protocol engines sit outside this block
`timescale 1ns/10ps
`include "dabc_cfg.svh"
module dabc_top #(
    parameter int WAIT_CYC = `DABC_WAIT_CYC  // boot wait, shorten in sim
) (
    input  wire logic        clk,
    input  wire logic        reset,
    // firmware controls
    input  wire logic        fw_debug_en,   // firmware enables debug
    input  wire logic        fw_scan_dis,   // firmware releases scan pins
    input  wire logic        fw_trace_en,   // firmware enables trace
    input  wire logic        security_set,  // permanent lock request
    input  wire logic        full_erase,    // whole device erase done
    input  wire logic        trst_used,     // board wires test reset
    // scan port pins
    input  wire logic        scan_clk_pin,
    input  wire logic        scan_mode_pin,
    input  wire logic        scan_din_pin,
    input  wire logic        scan_rst_n_pin,
    // two-wire debug pins
    input  wire logic        dbg_clk_pin,
    input  wire logic        dbg_dat_pin,
    // boot serial line command detect, from the I2C slave engine
    input  wire logic        boot_cmd,      // command seen, address checked here
    input  wire logic [6:0]  boot_addr_seen,
    input  wire logic [16:0] prog_addr,     // flash address being written
    input  wire logic        prog_wr,       // flash write request
    // outputs
    output logic             on_chip_debug_logic, // debug active
    output logic             scan_en,       // scan pins owned by scan port
    output logic             dbg_en,        // two-wire pins owned
    output logic             trace_en,      // single_wire_trace_port on
    output logic [2:0]       pins_used,
    output logic             scan_clk_rise, // sampled scan clock edge
    output logic             scan_mode_s,
    output logic             scan_din_s,
    output logic             scan_rst_s,
    output logic             dbg_clk_rise,
    output logic             dbg_dat_s,
    output logic             locked,        // security applied
    output logic             boot_active,   // loader waiting or loading
    output logic             app_start,     // hand over, one pulse
    output logic             boot_protect_hit, // loader write into its own area
    output logic [6:0]       boot_slave_addr
);
    // ---------------------------------------------------------------
    // synchronised pins
    // ---------------------------------------------------------------
    logic sclk_s, smode_s, sdin_s, srst_s, dclk_s, ddat_s;
    dabc_sync u_s0 (.clk(clk), .reset(reset), .din(scan_clk_pin),
                    .dout(sclk_s));
    dabc_sync u_s1 (.clk(clk), .reset(reset), .din(scan_mode_pin),
                    .dout(smode_s));
    dabc_sync u_s2 (.clk(clk), .reset(reset), .din(scan_din_pin),
                    .dout(sdin_s));
    // inverted ahead of the sync so its reset value is the idle level;
    // otherwise a released test reset pin looks asserted after reset
    dabc_sync u_s3 (.clk(clk), .reset(reset), .din(~scan_rst_n_pin),
                    .dout(srst_s));
    dabc_sync u_s4 (.clk(clk), .reset(reset), .din(dbg_clk_pin),
                    .dout(dclk_s));
    dabc_sync u_s5 (.clk(clk), .reset(reset), .din(dbg_dat_pin),
                    .dout(ddat_s));

    // ---------------------------------------------------------------
    // access state
    // ---------------------------------------------------------------
    logic lock_q = 1'b0;        // sticky fuse; power-on value only
    logic lock_d;
    logic dbg_q, dbg_d;
    logic scan_q, scan_d;
    logic trc_q, trc_d;
    logic sclk_q, sclk_d;       // previous scan clock sample
    logic dclk_q, dclk_d;
    logic [2:0] pins_q, pins_d;
    logic srise_q, srise_d, drise_q, drise_d;
    logic smode_q, smode_d, sdin_q, sdin_d, srst_q, srst_d;
    logic ddat_q, ddat_d;

    // next access state
    always_comb begin
        lock_d = lock_q | security_set;
        // debug stays off until firmware says so; an erase drops it,
        // so new firmware must enable it again
        dbg_d  = dbg_q;
        if (full_erase) begin
            dbg_d = 1'b0;
        end else if (fw_debug_en) begin
            dbg_d = 1'b1;
        end
        if (lock_d) begin
            dbg_d = 1'b0;
        end
        scan_d = ~fw_scan_dis & ~lock_d;
        trc_d  = fw_trace_en & dbg_d & ~lock_d;
        // pin budget per configuration
        if (scan_d) begin
            pins_d = trst_used ? `DABC_PINS_SCAN5
                               : `DABC_PINS_SCAN4;
        end else if (dbg_d && trc_d) begin
            pins_d = `DABC_PINS_TWO_TRC;
        end else if (dbg_d) begin
            pins_d = `DABC_PINS_TWO;
        end else if (trc_d) begin
            pins_d = `DABC_PINS_TRACE;
        end else begin
            pins_d = `DABC_PINS_NONE;
        end
        // edge detection after the synchronisers; the host keeps the
        // scan clock slow enough that every edge is seen
        sclk_d  = sclk_s;
        dclk_d  = dclk_s;
        // disabled ports present idle inputs to debug logic
        srise_d = scan_q & sclk_s & ~sclk_q;
        smode_d = scan_q & smode_s;
        sdin_d  = scan_q & sdin_s;
        srst_d  = scan_q & trst_used & srst_s;
        drise_d = dbg_q & dclk_s & ~dclk_q;
        ddat_d  = dbg_q & ddat_s;
    end

    // register access state
    always_ff @(posedge clk) begin
        if (reset) begin
            dbg_q   <= 1'b0;
            // a reset must not reopen the scan port once locked
            scan_q  <= ~lock_q;
            trc_q   <= 1'b0;
            pins_q  <= lock_q ? `DABC_PINS_NONE
                              : `DABC_PINS_SCAN4;
            sclk_q  <= 1'b0;
            dclk_q  <= 1'b0;
            srise_q <= 1'b0;
            smode_q <= 1'b0;
            sdin_q  <= 1'b0;
            srst_q  <= 1'b0;
            drise_q <= 1'b0;
            ddat_q  <= 1'b0;
        end else begin
            dbg_q   <= dbg_d;
            scan_q  <= scan_d;
            trc_q   <= trc_d;
            pins_q  <= pins_d;
            sclk_q  <= sclk_d;
            dclk_q  <= dclk_d;
            srise_q <= srise_d;
            smode_q <= smode_d;
            sdin_q  <= sdin_d;
            srst_q  <= srst_d;
            drise_q <= drise_d;
            ddat_q  <= ddat_d;
        end
    end

    // lock models a fuse: only power-on clears it, never reset
    always_ff @(posedge clk) begin
        lock_q <= lock_d;
    end

    // ---------------------------------------------------------------
    // boot loader sequencer
    // ---------------------------------------------------------------
    dabc_pkg::dabc_boot_e st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic        go_q, go_d;
    logic        hit_q, hit_d;
    logic        act_q, act_d;    // loader still owns the device
    logic [6:0]  addr_q, addr_d;  // slave address, held in a flop

    // next boot state
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        go_d  = 1'b0;
        case (st_q)
            dabc_pkg::DABC_WAIT: begin
                if (boot_cmd && boot_addr_seen == `DABC_BOOT_ADDR) begin
                    st_d = dabc_pkg::DABC_LOAD;
                end else if (cnt_q >= 32'(WAIT_CYC - 1)) begin
                    st_d = dabc_pkg::DABC_APP;
                    go_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            dabc_pkg::DABC_LOAD: begin
                st_d = dabc_pkg::DABC_LOAD;  // stays until device reset
            end
            dabc_pkg::DABC_APP: begin
                st_d = dabc_pkg::DABC_APP;
            end
            default: begin
                st_d = dabc_pkg::DABC_WAIT;
            end
        endcase
        // loader writing its own area is flagged; scan or two-wire
        // programming may overwrite it freely
        hit_d = prog_wr && (prog_addr < `DABC_BOOT_TOP)
                && st_q == dabc_pkg::DABC_LOAD
                && !(scan_q || dbg_q);
        // registered so the output does not decode the state word
        act_d  = (st_d != dabc_pkg::DABC_APP);
        addr_d = `DABC_BOOT_ADDR;
    end

    // register boot state
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q  <= dabc_pkg::DABC_WAIT;
            cnt_q <= 32'h0;
            go_q  <= 1'b0;
            hit_q <= 1'b0;
            act_q <= 1'b1;
            addr_q <= `DABC_BOOT_ADDR;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            go_q  <= go_d;
            hit_q <= hit_d;
            act_q <= act_d;
            addr_q <= addr_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all from flip-flops
    // ---------------------------------------------------------------
    assign on_chip_debug_logic = dbg_q;
    assign scan_en          = scan_q;
    assign dbg_en           = dbg_q;
    assign trace_en         = trc_q;
    assign pins_used        = pins_q;
    assign scan_clk_rise    = srise_q;
    assign scan_mode_s      = smode_q;
    assign scan_din_s       = sdin_q;
    assign scan_rst_s       = srst_q;
    assign dbg_clk_rise     = drise_q;
    assign dbg_dat_s        = ddat_q;
    assign locked           = lock_q;
    assign boot_active      = act_q;
    assign app_start        = go_q;
    assign boot_protect_hit = hit_q;
    assign boot_slave_addr  = addr_q;
endmodule : dabc_top

// [inc/dabc_cfg.svh]
// Purpose: constants for debug access and boot control
// Assumes: 250 MHz system clock
// Notes:   macro constants only; types live in dabc_pkg
`ifndef DABC_CFG_SVH
`define DABC_CFG_SVH
// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define DABC_CLK_MHZ        250
`define DABC_WAIT_S         2
`define DABC_WAIT_CYC       (`DABC_WAIT_S * `DABC_CLK_MHZ * 1000000)
`define DABC_SCAN_MAX_MHZ   14
// ---------------------------------------------------------------
// boot loader
// ---------------------------------------------------------------
`define DABC_BOOT_ADDR      7'h04
`define DABC_BOOT_KBPS      100
`define DABC_BOOT_KBYTES    9
`define DABC_BOOT_TOP       17'h02400
// ---------------------------------------------------------------
// pin counts per configuration
// ---------------------------------------------------------------
`define DABC_PINS_NONE      3'h0
`define DABC_PINS_SCAN4     3'h4
`define DABC_PINS_SCAN5     3'h5
`define DABC_PINS_TWO       3'h2
`define DABC_PINS_TRACE     3'h1
`define DABC_PINS_TWO_TRC   3'h3
`endif

// [inc/dabc_pkg.sv]
// Purpose: shared types for debug access and boot control
// Assumes: nothing beyond the cfg header
// Notes:   boot phase sequence only
package dabc_pkg;
    // ---------------------------------------------------------------
    // boot sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        DABC_WAIT,
        DABC_LOAD,
        DABC_APP
    } dabc_boot_e;
endpackage : dabc_pkg

// [verilog/dabc_sync.sv]
// Purpose: two flip-flop synchroniser for one pin
// Assumes: input asynchronous to clk
// Notes:   first stage read only by the second
`timescale 1ns/10ps
module dabc_sync (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;  // first stage
    logic meta_d;
    logic sync_q;  // second stage
    logic sync_d;

    // ---------------------------------------------------------------
    // next values
    // ---------------------------------------------------------------
    always_comb begin
        meta_d = din;
        sync_d = meta_q;
    end

    // register stages
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;
endmodule : dabc_sync

// [test/dabc_monitor.sv]
// Purpose: port assertions for dabc_top
// Assumes: one clock domain, sync active-high reset
// Notes:   bound from the bench top file
`timescale 1ns/10ps
module dabc_monitor (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        fw_debug_en,
    input wire logic        security_set,
    input wire logic        full_erase,
    input wire logic        prog_wr,
    input wire logic [16:0] prog_addr,
    input wire logic        on_chip_debug_logic,
    input wire logic        scan_en,
    input wire logic        dbg_en,
    input wire logic        trace_en,
    input wire logic        scan_clk_rise,
    input wire logic        scan_din_s,
    input wire logic        dbg_clk_rise,
    input wire logic        dbg_dat_s,
    input wire logic        locked,
    input wire logic        app_start,
    input wire logic        boot_active,
    input wire logic        boot_protect_hit
);
    // ---------------------------------------------------------------
    // properties, all on clk, dropped while reset is high
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_sec; security_set |=> locked; endproperty
    a_sec: assert property (p_sec) else $error("lock not set");
    property p_hold; locked |=> locked; endproperty
    a_hold: assert property (p_hold) else $error("lock lost");
    property p_off; locked |=> !(scan_en | dbg_en | trace_en); endproperty
    a_off: assert property (p_off) else $error("port open");
    property p_on;
        fw_debug_en && !full_erase && !security_set && !locked
            |=> on_chip_debug_logic;
    endproperty
    a_on: assert property (p_on) else $error("debug not on");
    property p_cause; $rose(on_chip_debug_logic) |-> $past(fw_debug_en);
    endproperty
    a_cause: assert property (p_cause) else $error("debug on");
    property p_erase; full_erase |=> !on_chip_debug_logic; endproperty
    a_erase: assert property (p_erase) else $error("erase");
    property p_trace; trace_en |-> on_chip_debug_logic; endproperty
    a_trace: assert property (p_trace) else $error("trace");
    // gating may lag by the output register, hence four idle cycles first
    property p_sgate; !scan_en [*4] |-> !scan_clk_rise && !scan_din_s;
    endproperty
    a_sgate: assert property (p_sgate) else $error("scan leak");
    property p_dgate; !dbg_en [*4] |-> !dbg_clk_rise && !dbg_dat_s;
    endproperty
    a_dgate: assert property (p_dgate) else $error("dbg leak");
    property p_app; app_start |=> !app_start && !boot_active; endproperty
    a_app: assert property (p_app) else $error("hand over");
    property p_hit;
        boot_protect_hit |-> $past(prog_wr) && $past(prog_addr) < 17'h02400;
    endproperty
    a_hit: assert property (p_hit) else $error("bad hit");
endmodule : dabc_monitor

// [test/dabc_host_model.sv]
// Purpose: debug host driving scan and two-wire pins
// Assumes: frame_go rising starts one burst
// Notes:   clock stands still between bursts; data never rests
`timescale 1ns/10ps
module dabc_host_model (
    input  wire logic frame_go,       // start a burst of eight clocks
    output logic      scan_clk_pin,
    output logic      scan_mode_pin,
    output logic      scan_din_pin,
    output logic      scan_rst_n_pin,
    output logic      dbg_clk_pin,
    output logic      dbg_dat_pin
);
    logic host_clk;                   // shared clock for both ports
    assign scan_clk_pin = host_clk;
    assign dbg_clk_pin  = host_clk;
    // idle levels; test reset pin present and released
    initial begin
        host_clk = 1'b0;
        scan_mode_pin = 1'b0;
        scan_din_pin = 1'b0;
        dbg_dat_pin = 1'b0;
        scan_rst_n_pin = 1'b1;
    end
    // data toggles so a stale pin level can never look valid
    always #24 begin
        scan_din_pin = ~scan_din_pin;
        dbg_dat_pin  = ~dbg_dat_pin;
    end
    // one burst: eight rising edges, 48 ns period, twelve system
    // clocks per period so every edge is sampled; mode held high and
    // test reset held low for the whole burst
    always @(posedge frame_go) begin
        scan_mode_pin = 1'b1;
        scan_rst_n_pin = 1'b0;
        repeat (8) begin
            #24 host_clk = 1'b1;
            #24 host_clk = 1'b0;
        end
        scan_mode_pin = 1'b0;
        scan_rst_n_pin = 1'b1;
    end
endmodule : dabc_host_model

// [test/tb_debug_access_and_boot_control.sv]
// Purpose: self-checking bench for dabc_top
// Assumes: boot wait shortened to 20 cycles
// Notes:   lock scenario runs last because the lock never clears
`timescale 1ns/10ps
module tb_debug_access_and_boot_control;
    localparam int WAIT = 20;         // shortened boot wait
    logic clk, reset, fw_debug_en, fw_scan_dis, fw_trace_en, frame_go;
    logic security_set, full_erase, trst_used, boot_cmd, prog_wr;
    logic [6:0] boot_addr_seen, boot_slave_addr;
    logic [16:0] prog_addr;
    logic [2:0] pins_used;
    logic s_clk, s_mode, s_din, s_rst_n, d_clk, d_dat;
    logic on_chip_debug_logic, scan_en, dbg_en, trace_en, locked;
    logic boot_active, app_start, boot_protect_hit, s_rise, d_rise;
    int num_errors, num_checks, cycles, n_scan, n_dbg, n_hit, n_app;
    logic s_mode_o, s_din_o, s_rst_o, d_dat_o;
    int n_mode, n_rst, n_din, n_dat;
    dabc_top #(.WAIT_CYC(WAIT)) dut_u (.clk(clk), .reset(reset),
        .fw_debug_en(fw_debug_en), .fw_scan_dis(fw_scan_dis),
        .fw_trace_en(fw_trace_en), .security_set(security_set),
        .full_erase(full_erase), .trst_used(trst_used),
        .scan_clk_pin(s_clk), .scan_mode_pin(s_mode),
        .scan_din_pin(s_din), .scan_rst_n_pin(s_rst_n),
        .dbg_clk_pin(d_clk), .dbg_dat_pin(d_dat), .boot_cmd(boot_cmd),
        .boot_addr_seen(boot_addr_seen), .prog_addr(prog_addr),
        .prog_wr(prog_wr), .on_chip_debug_logic(on_chip_debug_logic),
        .scan_en(scan_en), .dbg_en(dbg_en), .trace_en(trace_en),
        .pins_used(pins_used), .scan_clk_rise(s_rise),
        .scan_mode_s(s_mode_o), .scan_din_s(s_din_o),
        .scan_rst_s(s_rst_o),
        .dbg_clk_rise(d_rise), .dbg_dat_s(d_dat_o), .locked(locked),
        .boot_active(boot_active), .app_start(app_start),
        .boot_protect_hit(boot_protect_hit),
        .boot_slave_addr(boot_slave_addr));
    dabc_host_model host_u (.frame_go(frame_go), .scan_clk_pin(s_clk),
        .scan_mode_pin(s_mode), .scan_din_pin(s_din),
        .scan_rst_n_pin(s_rst_n), .dbg_clk_pin(d_clk),
        .dbg_dat_pin(d_dat));
    always #2 clk = ~clk;
    // event counters and hang guard
    always @(posedge clk) begin
        cycles++;
        if (s_rise === 1'b1) n_scan++;
        if (d_rise === 1'b1) n_dbg++;
        if (boot_protect_hit === 1'b1) n_hit++;
        if (app_start === 1'b1) n_app++;
        if (s_mode_o === 1'b1) n_mode++;
        if (s_rst_o === 1'b1) n_rst++;
        if (s_din_o === 1'b1) n_din++;
        if (d_dat_o === 1'b1) n_dat++;
        if (cycles == 3000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask : chk1
    task automatic chkn(input logic [16:0] got, input logic [16:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chkn
    task automatic do_reset();
        reset = 1'b1;
        step(6);
        reset = 1'b0;
    endtask : do_reset
    // em: cycles that mode and test reset stand, 8 periods x 12 clocks
    task automatic burst(input logic [16:0] es, input logic [16:0] ed,
                         input logic [16:0] em);
        n_scan = 0;
        n_dbg = 0;
        n_mode = 0;
        n_rst = 0;
        n_din = 0;
        n_dat = 0;
        frame_go = 1'b1;
        step(1);
        frame_go = 1'b0;
        step(120);
        chkn(17'(n_scan), es);
        chkn(17'(n_dbg), ed);
        chkn(17'(n_mode), em);
        chkn(17'(n_rst), em);
        chk1(n_din != 0, es != 17'h0);
        chk1(n_dat != 0, ed != 17'h0);
    endtask : burst
    task automatic wr(input logic [16:0] a);
        prog_addr = a;
        prog_wr = 1'b1;
        step(1);
        prog_wr = 1'b0;
        step(2);
    endtask : wr
    task automatic boot_run(input logic [6:0] a, input logic [16:0] apps);
        do_reset();
        n_app = 0;
        step(2);
        boot_addr_seen = a;
        boot_cmd = 1'b1;
        step(1);
        boot_cmd = 0;
        step(WAIT + 10);
        chkn(17'(n_app), apps);
        chk1(boot_active, apps == 17'h0);
    endtask : boot_run
    task automatic t_reset_vals();
        step(1);
        chk1(on_chip_debug_logic, 1'b0);
        chk1(scan_en, 1'b1);
        chkn(17'(pins_used), 17'h4);
        chkn(17'(boot_slave_addr), 17'h4);
    endtask : t_reset_vals
    task automatic t_debug();
        fw_trace_en = 1'b1;
        step(2);
        chk1(trace_en, 1'b0);
        fw_debug_en = 1'b1;
        step(1);
        fw_debug_en = 1'b0;
        step(1);
        chk1(dbg_en, 1'b1);
        fw_debug_en = 1'b1;
        full_erase = 1'b1;
        step(1);
        {fw_debug_en, full_erase} = 2'h0;
        step(1);
        chk1(on_chip_debug_logic, 1'b0);
        fw_debug_en = 1'b1;
        step(1);
        fw_debug_en = 1'b0;
        step(1);
        chk1(trace_en, 1'b1);
    endtask : t_debug
    task automatic t_pins();
        trst_used = 1'b1;
        step(2);
        chkn(17'(pins_used), 17'h5);
        fw_scan_dis = 1'b1;
        step(2);
        chkn(17'(pins_used), 17'h3);
        fw_trace_en = 1'b0;
        step(2);
        chkn(17'(pins_used), 17'h2);
        full_erase = 1'b1;
        step(1);
        full_erase = 1'b0;
        step(1);
        chkn(17'(pins_used), 17'h0);
    endtask : t_pins
    task automatic t_protect();
        n_hit = 0;
        wr(17'h023FF);
        chkn(17'(n_hit), 17'h1);
        wr(17'h02400);
        chkn(17'(n_hit), 17'h1);
        fw_scan_dis = 1'b0;
        step(2);
        wr(17'h00000);
        chkn(17'(n_hit), 17'h1);
    endtask : t_protect
    task automatic t_lock();
        security_set = 1'b1;
        step(1);
        security_set = 1'b0;
        fw_debug_en = 1'b1;
        step(2);
        chk1(locked, 1'b1);
        chk1(on_chip_debug_logic | scan_en, 1'b0);
        do_reset();
        step(1);
        chk1(locked & !scan_en & !dbg_en, 1'b1);
    endtask : t_lock
    task automatic summarize();
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize
    initial begin
        {clk, fw_debug_en, fw_scan_dis, fw_trace_en, frame_go} = 5'h0;
        {security_set, full_erase, trst_used, boot_cmd, prog_wr} = 5'h0;
        boot_addr_seen = 7'h00;
        prog_addr = 17'h00000;
        do_reset();
        t_reset_vals();
        t_debug();
        trst_used = 1'b1;
        burst(17'h8, 17'h8, 17'h60);
        t_pins();
        burst(17'h0, 17'h0, 17'h0);
        boot_run(7'h05, 17'h1);
        // loader left waiting in its load phase for the write checks
        boot_run(7'h04, 17'h0);
        t_protect();
        t_lock();
        summarize();
    end
endmodule : tb_debug_access_and_boot_control
bind dabc_top dabc_monitor mon_u (.clk(clk), .reset(reset),
    .fw_debug_en(fw_debug_en), .security_set(security_set),
    .full_erase(full_erase), .prog_wr(prog_wr), .prog_addr(prog_addr),
    .on_chip_debug_logic(on_chip_debug_logic), .scan_en(scan_en),
    .dbg_en(dbg_en), .trace_en(trace_en), .scan_clk_rise(scan_clk_rise),
    .scan_din_s(scan_din_s), .dbg_clk_rise(dbg_clk_rise),
    .dbg_dat_s(dbg_dat_s), .locked(locked), .app_start(app_start),
    .boot_active(boot_active), .boot_protect_hit(boot_protect_hit));
